// ---- test_timer_counter_access_logic.sv ----
/* Self-checking bench: programs, latches and reads the three counters.
   Assumes the package and the bound checker are compiled before it. */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end
module test_timer_counter_access_logic
   import timer_unit_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clock, rst, awvalid, wvalid, bready, arvalid, rready, cpu_sleep;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;    // Byte addresses
   logic [31:0] wdata, rdata;      // Bus data
   logic [3:0]  wstrb;             // Write strobes
   logic [1:0]  bresp, rresp;      // Responses
   logic [2:0]  gate, ext, tout;   // Counter pins
   int          bad_count, cmp_count, cycles;

   timer_counter_access_logic DUT (.clock(clock), .rst(rst), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .counter_gate_input(gate),
      .ext_clock_input(ext), .cpu_sleep(cpu_sleep), .timer_out(tout));

   // Clock and hang guard; the run needs well under a thousand cycles
   always #2 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         bad_count++;
         $display("ERROR t=%0t timeout", $time);
         complete_run();
      end
   end
   // ------------------------------------------------------------
   // Bus tasks: handshakes judged at the negedge before the taking edge
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, d, input logic [1:0] r = RESP_OKAY);
      logic aw_hit, w_hit, pend;
      @(posedge clock);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= {24'h0, d};
      wstrb   <= 4'hf;
      bready  <= 1'b1;
      // Each channel is let go at the edge that takes it, in either order
      do begin
         @(negedge clock);
         aw_hit = awvalid && awready;
         w_hit  = wvalid && wready;
         @(posedge clock);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
         pend = (awvalid && !aw_hit) || (wvalid && !w_hit);
      end while (pend);
      do @(negedge clock); while (!bvalid);
      `CHK(bresp, r)
      @(posedge clock);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e, input logic [7:0] m = 8'hff, input logic [1:0] r = RESP_OKAY);
      @(posedge clock);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do @(negedge clock); while (!arready);
      @(posedge clock);
      arvalid <= 1'b0;
      do @(negedge clock); while (!rvalid);
      `CHK({rresp, rdata & {24'hffffff, m}}, {r, 24'h0, e})
      @(posedge clock);
      rready <= 1'b0;
   endtask
   // One external tick: a rise seen on two successive clocks
   task automatic tick(input int i);
      @(posedge clock);
      ext[i] <= 1'b1;
      @(posedge clock);
      ext[i] <= 1'b0;
      @(posedge clock);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic latch_scn();
      rd(ADDR_CTL, 8'h00);
      rd(8'h20, 8'h00, 8'hff, RESP_SLVERR);
      wr(8'h20, 8'h00, RESP_SLVERR);
      wr(ADDR_CLKSRC, 8'h05);
      rd(ADDR_CLKSRC, 8'h05);
      wr(ADDR_CTL, 8'h30);
      wr(ADDR_DATA0, 8'h34);
      wr(ADDR_DATA0, 8'h12);
      repeat (4) tick(0);
      wr(ADDR_CTL, 8'h00);
      repeat (2) tick(0);
      wr(ADDR_CTL, 8'h00);
      rd(ADDR_DATA0, 8'h31);
      wr(ADDR_DATA0, 8'h78);
      rd(ADDR_DATA0, 8'h12);
      wr(ADDR_DATA0, 8'h56);
      rd(ADDR_DATA0, 8'h2f);
      rd(ADDR_DATA0, 8'h12);
   endtask
   task automatic readback_scn();
      tick(0);
      wr(ADDR_CTL, 8'hc2);
      tick(0);
      wr(ADDR_CTL, 8'hd2);
      rd(ADDR_DATA0, 8'h30);
      rd(ADDR_DATA0, 8'h78);
      rd(ADDR_DATA0, 8'h56);
      rd(ADDR_DATA0, 8'h77);
      rd(ADDR_DATA0, 8'h56);
   endtask
   // A counter stopped by its gate ignores ticks, so a plain read is stable
   task automatic gate_scn();
      @(posedge clock);
      gate[0] <= 1'b0;
      repeat (3) tick(0);
      rd(ADDR_DATA0, 8'h77);
      rd(ADDR_DATA0, 8'h56);
      gate[0] <= 1'b1;
      tick(0);
      rd(ADDR_DATA0, 8'h76);
      rd(ADDR_DATA0, 8'h56);
   endtask
   // Internal source must stand still while asleep, so the count stays unloaded
   task automatic sleep_scn();
      @(posedge clock);
      cpu_sleep <= 1'b1;
      wr(ADDR_CTL, 8'h55);
      wr(8'h08, 8'h05);
      repeat (12) @(posedge clock);
      wr(ADDR_CTL, 8'he4);
      rd(8'h08, 8'h55);
      cpu_sleep <= 1'b0;
      repeat (8) @(posedge clock);
      wr(ADDR_CTL, 8'he4);
      rd(8'h08, 8'h15, 8'h7f);
   endtask
   task automatic zero_scn();
      wr(ADDR_CTL, 8'h91);
      wr(ADDR_DATA2, 8'h00);
      repeat (2) tick(2);
      wr(ADDR_CTL, 8'h80);
      rd(ADDR_DATA2, 8'h99);
      wr(ADDR_CTL, 8'ha0);
      wr(ADDR_DATA2, 8'h00);
      repeat (2) tick(2);
      wr(ADDR_CTL, 8'h80);
      rd(ADDR_DATA2, 8'hff);
      // Mode 0 from a count of 2: output rises as the count leaves 1
      wr(ADDR_CTL, 8'h90);
      wr(ADDR_DATA2, 8'h02);
      repeat (3) tick(2);
      @(negedge clock);
      `CHK(tout[2], 1'b1)
      wr(ADDR_CTL, 8'he8);
      rd(ADDR_DATA2, 8'h90);
   endtask
   // ------------------------------------------------------------
   // Verdict and main sequence
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, cpu_sleep} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      gate = 3'h7;
      ext = 3'h0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      latch_scn();
      readback_scn();
      gate_scn();
      sleep_scn();
      zero_scn();
      complete_run();
   end
endmodule

// ---- timer_counter_access_logic.sv ----
/*
 * Programming and access logic of a three-channel 16-bit timer unit behind
 * an AXI4-Lite slave: control word decode, counter-latch and read-back,
 * byte-wide count load and read, and simple down counters.
 * Assumes gate, external clock and sleep inputs are synchronous to clock.
 */
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module timer_counter_access_logic
   import timer_unit_pkg::*;
#(
   parameter int NUM_CNT = 3                  // Counters in the unit
) (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               rst,
   // AXI4-Lite write address
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [7:0]         awaddr,
   // AXI4-Lite write data
   input  wire logic               wvalid,
   output logic                    wready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   // AXI4-Lite write response
   output logic                    bvalid,
   input  wire logic               bready,
   output logic [1:0]              bresp,
   // AXI4-Lite read address
   input  wire logic               arvalid,
   output logic                    arready,
   input  wire logic [7:0]         araddr,
   // AXI4-Lite read data
   output logic                    rvalid,
   input  wire logic               rready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   // Counter pins
   input  wire logic [NUM_CNT-1:0] counter_gate_input,
   input  wire logic [NUM_CNT-1:0] ext_clock_input,
   input  wire logic               cpu_sleep,    // Idle or powerdown
   output logic [NUM_CNT-1:0]      timer_out
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // One step down; binary 0 wraps to ffff, BCD 0000 wraps to 9999
   function automatic logic [15:0] dec_count(input logic [15:0] v, input logic bcd);
      logic [15:0] r;
      logic        borrow;
      r      = v - 16'h0001;
      borrow = 1'b1;
      if (bcd) begin
         r = v;
         for (int d = 0; d < 4; d++) begin
            if (borrow) begin
               if (v[d*4 +: 4] == 4'h0) begin
                  r[d*4 +: 4] = 4'h9;
               end else begin
                  r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                  borrow      = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   // Counter index of a data port address, or NUM_CNT if not a data port
   function automatic int port_index(input logic [7:0] a);
      if (a >= ADDR_DATA0 && a <= ADDR_DATA2 && a[1:0] == 2'b00) begin
         return int'(a[3:2]) - 1;
      end
      return NUM_CNT;
   endfunction

   // ------------------------------------------------------------------
   // Bus slave state
   // ------------------------------------------------------------------
   logic              aw_have_q;              // Write address held
   logic [7:0]        aw_addr_q;              // Held write address
   logic              w_have_q;               // Write data held
   logic [31:0]       w_data_q;               // Held write data
   logic              w_lane0_q;              // Low byte lane enabled
   logic              wr_fire;                // Write takes effect now
   logic              rd_fire;                // Read takes effect now
   logic [7:0]        rd_byte;                // Byte a data port read returns
   logic              rd_ok;                  // Read address is mapped

   // ------------------------------------------------------------------
   // Counter state
   // ------------------------------------------------------------------
   logic [5:0]        ctl_q       [NUM_CNT];  // Order, mode, format
   logic [15:0]       cnt_q       [NUM_CNT];  // Live count
   logic [15:0]       pend_q      [NUM_CNT];  // Written count
   logic [7:0]        wlow_q      [NUM_CNT];  // First byte of a two-byte write
   logic [15:0]       latch_q     [NUM_CNT];  // Latched count
   logic [7:0]        stat_q      [NUM_CNT];  // Latched status
   logic [NUM_CNT-1:0] cnt_lat_q;             // Count latched, unread
   logic [NUM_CNT-1:0] st_lat_q;              // Status latched, unread
   logic [NUM_CNT-1:0] rd_hi_q;               // Next read is high byte
   logic [NUM_CNT-1:0] wr_hi_q;               // Next write is high byte
   logic [NUM_CNT-1:0] null_q;                // Written count not loaded
   logic [NUM_CNT-1:0] load_q;                // Load due on next tick
   logic [NUM_CNT-1:0] out_q;                 // Output pin level
   logic [NUM_CNT-1:0] clksrc_q;              // 1 selects external clock
   logic [NUM_CNT-1:0] ext_prev_q;            // Previous external level
   logic [NUM_CNT-1:0] tick;                  // Count enable per counter
   logic [7:0]        pre_q;                  // Prescaler count
   logic              int_tick;               // Internal prescaled tick

   // ------------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ------------------------------------------------------------------
   assign wr_fire = aw_have_q & w_have_q & ~bvalid;

   // Address and data holding, one item each
   always_ff @(posedge clock) begin
      if (rst) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awready   <= 1'b1;
         wready    <= 1'b1;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_lane0_q <= 1'b0;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= awaddr;
            awready   <= 1'b0;
         end
         if (wvalid && wready) begin
            w_have_q  <= 1'b1;
            w_data_q  <= wdata;
            w_lane0_q <= wstrb[0];
            wready    <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready   <= 1'b1;
            wready    <= 1'b1;
         end
      end
   end

   // Write response; unmapped addresses answer with an error
   always_ff @(posedge clock) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= (aw_addr_q == ADDR_CTL || aw_addr_q == ADDR_CLKSRC ||
                    port_index(aw_addr_q) < NUM_CNT) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Read channel: one read at a time, side effects at address accept
   // ------------------------------------------------------------------
   assign rd_fire = arvalid & arready;

   // Data port byte: status first, then latched count, else live count
   always_comb begin
      int        k;
      logic [15:0] src;
      k       = port_index(araddr);
      rd_byte = 8'h00;
      src     = 16'h0000;
      if (k < NUM_CNT) begin
         src = cnt_lat_q[k] ? latch_q[k] : cnt_q[k];
         if (st_lat_q[k]) begin
            rd_byte = stat_q[k];
         end else if (ctl_q[k][5:4] == RW_MSB ||
                      (ctl_q[k][5:4] != RW_LSB && rd_hi_q[k])) begin
            rd_byte = src[15:8];
         end else begin
            rd_byte = src[7:0];
         end
      end
   end

   assign rd_ok = (araddr == ADDR_CTL) || (araddr == ADDR_CLKSRC) || (port_index(araddr) < NUM_CNT);

   // Read data and response registers
   always_ff @(posedge clock) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else if (rd_fire) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         // Control word is write only and reads as zero
         if (araddr == ADDR_CLKSRC) begin
            rdata <= 32'(clksrc_q);
         end else begin
            rdata <= {24'h0, rd_byte};
         end
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Clock sources
   // ------------------------------------------------------------------
   // Prescaler halts while the processor sleeps; the external source does not
   always_ff @(posedge clock) begin
      if (rst) begin
         pre_q    <= 8'h00;
         int_tick <= 1'b0;
      end else begin
         int_tick <= 1'b0;
         if (!cpu_sleep) begin
            if (pre_q == PRESCALE_CYCLES - 8'h01) begin
               pre_q    <= 8'h00;
               int_tick <= 1'b1;
            end else begin
               pre_q <= pre_q + 8'h01;
            end
         end
      end
   end

   // Source select register and external edge history
   always_ff @(posedge clock) begin
      if (rst) begin
         clksrc_q   <= CLKSRC_RESET;
         ext_prev_q <= '0;
      end else begin
         ext_prev_q <= ext_clock_input;
         if (wr_fire && w_lane0_q && aw_addr_q == ADDR_CLKSRC) begin
            clksrc_q <= w_data_q[NUM_CNT-1:0];
         end
      end
   end

   // Gate stops a counter, so a plain read is stable
   assign tick = (clksrc_q & ext_clock_input & ~ext_prev_q |
                  ~clksrc_q & {NUM_CNT{int_tick}}) & counter_gate_input;

   // ------------------------------------------------------------------
   // Counters, latches and byte pointers
   // ------------------------------------------------------------------
   // Later statements win: a reprogram overrides a tick's load, null and output updates in the same cycle, but the count still steps
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            ctl_q[i]   <= CTL_RESET;
            cnt_q[i]   <= 16'h0000;
            pend_q[i]  <= 16'h0000;
            wlow_q[i]  <= 8'h00;
            latch_q[i] <= 16'h0000;
            stat_q[i]  <= 8'h00;
         end
         cnt_lat_q <= '0;
         st_lat_q  <= '0;
         rd_hi_q   <= '0;
         wr_hi_q   <= '0;
         null_q    <= '0;
         load_q    <= '0;
         out_q     <= '0;
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            // Counting; modes 2 and 3 reload, the others wrap from 0 to the maximum
            if (tick[i]) begin
               if (load_q[i]) begin
                  cnt_q[i]  <= pend_q[i];
                  load_q[i] <= 1'b0;
                  null_q[i] <= 1'b0;
               end else if (ctl_q[i][PERIOD_BIT] && cnt_q[i] == 16'h0001) begin
                  cnt_q[i] <= pend_q[i];
                  out_q[i] <= ~out_q[i];
               end else begin
                  cnt_q[i] <= dec_count(cnt_q[i], ctl_q[i][0]);
                  if (cnt_q[i] == 16'h0001) begin
                     out_q[i] <= 1'b1;
                  end
               end
            end
            // Data port read: release latches as they are consumed
            if (rd_fire && port_index(araddr) == i) begin
               if (st_lat_q[i]) begin
                  st_lat_q[i] <= 1'b0;
               end else if (ctl_q[i][5:4] == RW_LSB || ctl_q[i][5:4] == RW_MSB) begin
                  cnt_lat_q[i] <= 1'b0;
               end else begin
                  rd_hi_q[i] <= ~rd_hi_q[i];
                  if (rd_hi_q[i]) begin
                     cnt_lat_q[i] <= 1'b0;
                  end
               end
            end
            if (wr_fire && w_lane0_q) begin
               // Data port write: count only, programming untouched
               if (port_index(aw_addr_q) == i) begin
                  if (ctl_q[i][5:4] == RW_LSB) begin
                     pend_q[i] <= {8'h00, w_data_q[7:0]};
                     load_q[i] <= 1'b1;
                     null_q[i] <= 1'b1;
                  end else if (ctl_q[i][5:4] == RW_MSB) begin
                     pend_q[i] <= {w_data_q[7:0], 8'h00};
                     load_q[i] <= 1'b1;
                     null_q[i] <= 1'b1;
                  end else if (!wr_hi_q[i]) begin
                     wlow_q[i]  <= w_data_q[7:0];
                     wr_hi_q[i] <= 1'b1;
                  end else begin
                     pend_q[i]  <= {w_data_q[7:0], wlow_q[i]};
                     wr_hi_q[i] <= 1'b0;
                     load_q[i]  <= 1'b1;
                     null_q[i]  <= 1'b1;
                  end
               end
               if (aw_addr_q == ADDR_CTL) begin
                  if (w_data_q[7:SEL_LO] == SEL_READBACK) begin
                     // Read-back: selects in bits 3-1, count and status latch bits low-active
                     if (w_data_q[RB_SEL_LO + i]) begin
                        if (!w_data_q[RB_NCNT] && !cnt_lat_q[i]) begin
                           latch_q[i]   <= cnt_q[i];
                           cnt_lat_q[i] <= 1'b1;
                        end
                        if (!w_data_q[RB_NSTAT] && !st_lat_q[i]) begin
                           stat_q[i]   <= {out_q[i], null_q[i], ctl_q[i]};
                           st_lat_q[i] <= 1'b1;
                        end
                     end
                  end else if (int'(w_data_q[7:SEL_LO]) == i) begin
                     if (w_data_q[5:RW_LO] == RW_LATCH) begin
                        // Counter-latch: counter runs on, repeats ignored
                        if (!cnt_lat_q[i]) begin
                           latch_q[i]   <= cnt_q[i];
                           cnt_lat_q[i] <= 1'b1;
                        end
                     end else begin
                        // Reprogram: new order, mode, format; latches dropped
                        ctl_q[i]     <= w_data_q[5:0];
                        cnt_lat_q[i] <= 1'b0;
                        st_lat_q[i]  <= 1'b0;
                        rd_hi_q[i]   <= 1'b0;
                        wr_hi_q[i]   <= 1'b0;
                        load_q[i]    <= 1'b0;
                        null_q[i]    <= 1'b1;
                        out_q[i]     <= 1'b0;
                     end
                  end
               end
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------------
   assign timer_out = out_q;

endmodule

// ---- timer_unit_chk.sv ----
/* Concurrent checks on the register bus ports of the timer access logic.
   Assumes the timer unit package is compiled first; bound below. */
`timescale 1ns/1ps
module timer_unit_chk
   import timer_unit_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Write side
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [1:0]  bresp,
   // Read side
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [7:0]  araddr,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp
);
   // One domain, so clock and reset are given once
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Handshakes: refusal and holding of answers
   // ------------------------------------------------------------
   aw_refuse_a: assert property (awvalid && awready |=> !awready) else $error("awready high after take");
   rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready) else $error("read answer late");
   rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
   wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write resp moved");
   wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
      else $error("write response missing");
   // ------------------------------------------------------------
   // Data contents: byte wide, write-only control, unmapped places
   // ------------------------------------------------------------
   byte_wide_a: assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("upper read bits set");
   ctl_wo_a: assert property (arvalid && arready && araddr == ADDR_CTL |=> rdata == 32'h0)
      else $error("control word readable");
   unmapped_a: assert property (arvalid && arready && araddr > ADDR_CLKSRC |=> rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
endmodule
bind timer_counter_access_logic timer_unit_chk chk (.clock(clock), .rst(rst), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
   .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
   .rdata(rdata), .rresp(rresp));

// ---- timer_unit_pkg.sv ----
/*
 * Constants for the three-channel timer access logic: register offsets,
 * control word field positions, encodings and reset values.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.
 */
package timer_unit_pkg;

   // -------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTL    = 8'h00;  // Control word, write only
   localparam logic [7:0] ADDR_DATA0  = 8'h04;  // Counter 0 data port
   localparam logic [7:0] ADDR_DATA2  = 8'h0c;  // Counter 2 data port
   localparam logic [7:0] ADDR_CLKSRC = 8'h10;  // Clock source select

   // -------------------------------------------------------------------
   // Control word fields
   // -------------------------------------------------------------------
   localparam int SEL_LO     = 6;               // Counter select, bits 7-6
   localparam int RW_LO      = 4;               // Byte access order, bits 5-4
   localparam int PERIOD_BIT = 2;               // Mode bit that marks modes 2/3
   localparam int RB_NCNT    = 5;               // Read-back: high suppresses count
   localparam int RB_NSTAT   = 4;               // Read-back: high suppresses status
   localparam int RB_SEL_LO  = 1;               // Read-back: counter bits 3-1

   localparam logic [1:0] SEL_READBACK = 2'b11;
   localparam logic [1:0] RW_LATCH     = 2'b00;
   localparam logic [1:0] RW_LSB       = 2'b01;
   localparam logic [1:0] RW_MSB       = 2'b10;

   // -------------------------------------------------------------------
   // Reset values and counts
   // -------------------------------------------------------------------
   localparam logic [5:0] CTL_RESET      = 6'h00;
   localparam logic [2:0] CLKSRC_RESET   = 3'h0;
   localparam logic [7:0] PRESCALE_CYCLES = 8'h04;  // Clock cycles per internal tick

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
